// ---- include/psim_defines.vh ----
// offsets, field layout, reset values and timing counts for the slot interrupt mask block
`ifndef PSIM_DEFINES_VH
`define PSIM_DEFINES_VH

`define PSIM_OFS_PENDING     4'h0
`define PSIM_OFS_MASK        4'h4
`define PSIM_NUM_SRC         12
`define PSIM_SLOT0_LSB       0
`define PSIM_SLOT1_LSB       4
`define PSIM_SLOT2_LSB       8
`define PSIM_MASK_RESET      12'h000
`define PSIM_PEND_RESET      12'h000
`define PSIM_CLK_PERIOD_NS   8
`define PSIM_NUM_CS          8
`define PSIM_BUF_CS_MAP      8'hdb
`define PSIM_CTRL_CS         3

`endif

// ---- src/psim_xcvr_gate.v ----
// data transceiver enable for the buffered chip-select segment
`timescale 1ns/100ps
`include "psim_defines.vh"

module psim_xcvr_gate #(
    parameter NUM_CS     = `PSIM_NUM_CS,
    parameter BUF_CS_MAP = `PSIM_BUF_CS_MAP
) (
    input  wire              clk,
    input  wire              rstn,
    input  wire [NUM_CS-1:0] cs_n,
    input  wire [NUM_CS-1:0] region_disable,
    input  wire              hreset_cfg,
    output reg               xcvr_open_q
);

    wire [NUM_CS-1:0] buf_map = BUF_CS_MAP;
    wire [NUM_CS-1:0] valid_hit;

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < NUM_CS; i = i + 1) begin : g_cs
            // unbuffered and disabled regions never open the segment
            assign valid_hit[i] = ~cs_n[i] & buf_map[i] & ~region_disable[i];
        end
    endgenerate

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xcvr_open_q <= 1'b0;
        end else begin
            xcvr_open_q <= (|valid_hit) | hreset_cfg;
        end
    end

endmodule // psim_xcvr_gate

// ---- src/psim_top.v ----
// slot interrupt pending and mask registers with combined request and transceiver gate
// Function
// - mask bit one blocks, zero passes source
// - slots 0,1,2 lines a-d at bits 0,4,8
// - twelve mask bits read/write, reset to zero
// - transceivers open on valid buffered access, hreset
// - disabled buffered region keeps transceivers closed
// - unbuffered region keeps buffered transceivers closed
// - slot line sets unmasked pending bits of sources
// - pending at offset 0, mask at 4
// - all pending merged into one active-low request
`timescale 1ns/100ps
`include "psim_defines.vh"

module psim_top #(
    parameter NUM_SRC    = `PSIM_NUM_SRC,
    parameter NUM_CS     = `PSIM_NUM_CS,
    parameter BUF_CS_MAP = `PSIM_BUF_CS_MAP
) (
    input  wire              clk,
    input  wire              rstn,
    input  wire [NUM_CS-1:0] cs_n,
    input  wire [3:0]        addr,
    input  wire              wr_n,
    input  wire              rd_n,
    input  wire [31:0]       wdata,
    input  wire [31:0]       pend_clear,
    input  wire [NUM_CS-1:0] region_disable,
    input  wire              hreset_cfg,
    input  wire [3:0]        slot0_int_n,
    input  wire [3:0]        slot1_int_n,
    input  wire [3:0]        slot2_int_n,
    output reg  [31:0]       rdata_q,
    output reg               combined_interrupt_request_n_q,
    output wire              xcvr_open_q
);

    reg  [NUM_SRC-1:0] mask_q;
    reg  [NUM_SRC-1:0] mask_d;
    reg  [NUM_SRC-1:0] pend_q;
    reg  [NUM_SRC-1:0] pend_d;
    wire [NUM_SRC-1:0] src_req;
    wire               sel;
    wire               wr_mask;
    wire               rd_en;

    wire mask_slot0_line_a = mask_q[`PSIM_SLOT0_LSB + 0];
    wire mask_slot2_line_d = mask_q[`PSIM_SLOT2_LSB + 3];

    ////////////////////////////////////////////////////////////////////////
    // slot lines are active low; bit order slot0 a-d, slot1 a-d, slot2 a-d
    assign src_req = {~slot2_int_n, ~slot1_int_n, ~slot0_int_n};

    assign sel     = ~cs_n[`PSIM_CTRL_CS];
    assign wr_mask = sel & ~wr_n & (addr == `PSIM_OFS_MASK);
    assign rd_en   = sel & ~rd_n;

    always @* begin
        mask_d = mask_q;
        if (wr_mask) begin
            // only the low twelve bits are stored; upper write data dropped
            mask_d = wdata[NUM_SRC-1:0];
        end
    end

    always @* begin
        // clear first, then set, so a request in the clear cycle is kept
        pend_d = pend_q & ~pend_clear[NUM_SRC-1:0];
        pend_d = pend_d | (src_req & ~mask_q);
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= `PSIM_MASK_RESET;
            pend_q <= `PSIM_PEND_RESET;
        end else begin
            mask_q <= mask_d;
            pend_q <= pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data is registered: one cycle after the strobe
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h00000000;
        end else if (rd_en) begin
            case (addr)
                `PSIM_OFS_PENDING: rdata_q <= {20'h00000, pend_q};
                `PSIM_OFS_MASK:    rdata_q <= {20'h00000, mask_q};
                default:           rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            combined_interrupt_request_n_q <= 1'b1;
        end else begin
            combined_interrupt_request_n_q <= ~(|pend_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    psim_xcvr_gate #(
        .NUM_CS     (NUM_CS),
        .BUF_CS_MAP (BUF_CS_MAP)
    ) u_xcvr (
        .clk            (clk),
        .rstn           (rstn),
        .cs_n           (cs_n),
        .region_disable (region_disable),
        .hreset_cfg     (hreset_cfg),
        .xcvr_open_q    (xcvr_open_q)
    );

endmodule // psim_top

// ---- tb/psim_checker.sv ----
// port assertions for the slot interrupt mask block
`timescale 1ns/100ps
module psim_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  cs_n,
    input wire logic        rd_n,
    input wire logic [7:0]  region_disable,
    input wire logic        hreset_cfg,
    input wire logic [31:0] rdata_q,
    input wire logic        xcvr_open_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    cfg_open_a: assert property (hreset_cfg |=> xcvr_open_q)
        else $error("closed in config");
    unbuf_shut_a: assert property (cs_n == 8'hfb && !hreset_cfg |=> !xcvr_open_q)
        else $error("open on unbuffered");
    dis_shut_a: assert property (cs_n == 8'hf7 && region_disable[3] && !hreset_cfg
        |=> !xcvr_open_q) else $error("open when disabled");
    resv_zero_a: assert property (!cs_n[3] && !rd_n |=> rdata_q[31:12] == 20'h0)
        else $error("reserved bits set");
    idle_shut_a: assert property (cs_n == 8'hff && !hreset_cfg |=> !xcvr_open_q)
        else $error("open with no access");
    buf_open_a: assert property (cs_n == 8'hf7 && !region_disable[3] |=> xcvr_open_q)
        else $error("closed on buffered access");
    cover property (!cs_n[3] && !rd_n);
    cover property (hreset_cfg);
    cover property (region_disable[3] && cs_n == 8'hf7);
endmodule // psim_checker
bind psim_top psim_checker u_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
    .region_disable(region_disable), .hreset_cfg(hreset_cfg), .rdata_q(rdata_q),
    .xcvr_open_q(xcvr_open_q));

// ---- tb/psim_host.sv ----
// host local bus model: one access per call, held a full cycle
`timescale 1ns/100ps
module psim_host (
    input  wire logic        clk,
    output logic      [7:0]  cs_n,
    output logic      [3:0]  addr,
    output logic             wr_n,
    output logic             rd_n,
    output logic      [31:0] wdata
);
    initial {cs_n, addr, wr_n, rd_n, wdata} = {8'hff, 4'h0, 2'h3, 32'h0};
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [7:0] c);
        @(negedge clk);
        {cs_n, addr, wdata, wr_n, rd_n} = {c, a, d, ~w, w};
        @(negedge clk);
        {cs_n, wr_n, rd_n} = {8'hff, 2'h3};
        // released data is scrambled so stale values are never trusted
        wdata = ~wdata;
    endtask
endmodule // psim_host

// ---- tb/test_psim_top.sv ----
// self-checking bench for the slot interrupt mask block
`timescale 1ns/100ps
`include "psim_defines.vh"
module test_psim_top;
    logic        clk = 1'b0, rstn = 1'b0, hreset_cfg = 1'b0;
    logic [7:0]  region_disable = 8'h00;
    logic [31:0] pend_clear = 32'h0, d;
    logic [11:0] slot_n = 12'hfff;
    wire  [7:0]  cs_n;
    wire  [3:0]  addr;
    wire         wr_n, rd_n, irq_n, xcvr;
    wire  [31:0] wdata, rdata_q;
    int          errors = 0, n_tests = 0;
    always #4 clk = ~clk;
    psim_host u_host (.clk(clk), .cs_n(cs_n), .addr(addr), .wr_n(wr_n), .rd_n(rd_n),
        .wdata(wdata));
    psim_top u_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .addr(addr), .wr_n(wr_n),
        .rd_n(rd_n), .wdata(wdata), .pend_clear(pend_clear), .region_disable(region_disable),
        .hreset_cfg(hreset_cfg), .slot0_int_n(slot_n[3:0]), .slot1_int_n(slot_n[7:4]),
        .slot2_int_n(slot_n[11:8]), .rdata_q(rdata_q), .combined_interrupt_request_n_q(irq_n),
        .xcvr_open_q(xcvr));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp);
        u_host.acc(1'b0, a, 32'h0, 8'hf7);
        chk(rdata_q, exp);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [31:0] open_exp(int i, logic [7:0] dis);
        logic [7:0] hit;
        hit = (`PSIM_BUF_CS_MAP & ~dis) >> i;
        return {31'h0, hit[0]};
    endfunction
    initial begin
        void'($urandom(32'h15e4));
        repeat (3) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        rd(4'h4, 32'h0);
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h0);
        for (int k = 0; k < 5; k++) begin
            d = (k == 0) ? 32'hffff_f000 : $urandom;
            u_host.acc(1'b1, 4'h4, d, 8'hf7);
            rd(4'h4, {20'h0, d[11:0]});
            slot_n = 12'h000;
            @(negedge clk) slot_n = 12'hfff;
            repeat (2) @(negedge clk);
            rd(4'h0, {20'h0, ~d[11:0]});
            chk({31'h0, irq_n}, {31'h0, &d[11:0]});
            pend_clear = 32'hfff;
            @(negedge clk) pend_clear = 32'h0;
        end
        $display("mask and pending test done");
        for (int i = 0; i < 8; i++) begin
            region_disable = $urandom;
            u_host.acc(1'b0, 4'h8, 32'h0, ~(8'h01 << i));
            chk({31'h0, xcvr}, open_exp(i, region_disable));
        end
        hreset_cfg = 1'b1;
        @(negedge clk) hreset_cfg = 1'b0;
        chk({31'h0, xcvr}, 32'h1);
        $display("transceiver test done");
        wrap_up;
    end
    // far longer than the 76 cycles the tests need
    initial begin
        #20000;
        errors++;
        wrap_up;
    end
endmodule // test_psim_top
